// [design/mic_amp_control_registers.sv]
// serial bus write-only slave and control register bank for the mic amplifier
`timescale 1ns/1ps
module mic_amp_control_registers
   import mic_amp_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
   input  wire logic                         i_core_clk,
   input  wire logic                         i_rst,
   input  wire logic                         i_scl,
   input  wire logic                         i_sda,
   output logic                              o_sda,
   output logic                              o_sda_oe_n,
   output logic [3:0]                        o_pre_gain,
   output logic [2:0]                        o_post_gain,
   output logic                              o_mute_ch1,
   output logic                              o_mute_ch2,
   output logic                              o_en_ch1,
   output logic                              o_en_ch2,
   output logic [1:0]                        o_mode,
   output logic                              o_output_lowpass_path
);
   import mic_amp_pkg::*;

   typedef enum {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_DATA, ST_DATA_ACK, ST_IGNORE} bus_state_e;

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic scl_s;
   logic sda_s;

   mic_amp_sync #(.RESET_VAL(1'b1)) u_sync_scl (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_async    (i_scl),
      .o_sync     (scl_s)
   );

   mic_amp_sync #(.RESET_VAL(1'b1)) u_sync_sda (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_async    (i_sda),
      .o_sync     (sda_s)
   );

   // post-amp code saturates at the top step
   function automatic logic [2:0] post_sat(input logic [2:0] code);
      post_sat = (code >= POST_SAT_CODE) ? POST_SAT_CODE : code;
   endfunction

   // ------------------------------------------------------------
   // bus state
   // ------------------------------------------------------------
   bus_state_e       state_reg, state_next;
   logic             scl_d_reg, scl_d_next;
   logic             sda_d_reg, sda_d_next;
   logic [3:0]       cnt_reg, cnt_next;
   logic [7:0]       shift_reg, shift_next;
   logic             ack_drv_reg, ack_drv_next;
   logic             ack_seen_reg, ack_seen_next;
   gain_setting_s    gain_reg, gain_next;
   channel_control_s chan_reg, chan_next;

   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;

   assign scl_rise   = scl_s & ~scl_d_reg;
   assign scl_fall   = ~scl_s & scl_d_reg;
   assign start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
   assign stop_cond  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

   always_comb begin
      state_next    = state_reg;
      scl_d_next    = scl_s;
      sda_d_next    = sda_s;
      cnt_next      = cnt_reg;
      shift_next    = shift_reg;
      ack_drv_next  = ack_drv_reg;
      ack_seen_next = ack_seen_reg;
      gain_next     = gain_reg;
      chan_next     = chan_reg;
      // framing events also drop a half-seen acknowledge clock
      if (start_cond) begin
         state_next    = ST_ADDR;
         cnt_next      = '0;
         ack_drv_next  = 1'b0;
         ack_seen_next = 1'b0;
      end else if (stop_cond) begin
         state_next    = ST_IDLE;
         ack_drv_next  = 1'b0;
         ack_seen_next = 1'b0;
      end else begin
         case (state_reg)
            ST_ADDR, ST_DATA: begin
               if (scl_rise) begin
                  shift_next = {shift_reg[6:0], sda_s};
                  cnt_next   = cnt_reg + 4'h1;
               end else if (scl_fall && cnt_reg == BITS_PER_BYTE) begin
                  cnt_next = '0;
                  if (state_reg == ST_ADDR) begin
                     // reads and other addresses get no acknowledge
                     if (shift_reg[7:1] == DEV_ADDR && shift_reg[RW_BIT] == RW_WRITE) begin
                        state_next   = ST_ADDR_ACK;
                        ack_drv_next = 1'b1;
                     end else begin
                        state_next = ST_IGNORE;
                     end
                  end else begin
                     state_next   = ST_DATA_ACK;
                     ack_drv_next = 1'b1;
                  end
               end
            end
            ST_ADDR_ACK, ST_DATA_ACK: begin
               if (scl_rise) begin
                  ack_seen_next = 1'b1;
               end else if (scl_fall && ack_seen_reg) begin
                  ack_seen_next = 1'b0;
                  ack_drv_next  = 1'b0;
                  state_next    = ST_DATA;
                  // commit only after the acknowledge clock has completed
                  if (state_reg == ST_DATA_ACK) begin
                     if (shift_reg[SEL_BIT] == SEL_GAIN) begin
                        gain_next = gain_setting_s'(shift_reg[6:0]);
                     end else begin
                        chan_next = channel_control_s'(shift_reg[6:0]);
                     end
                  end
               end
            end
            ST_IGNORE: begin
               state_next = ST_IGNORE;
            end
            ST_IDLE: begin
               state_next = ST_IDLE;
            end
            default: begin
               state_next = ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         state_reg    <= ST_IDLE;
         scl_d_reg    <= 1'b1;
         sda_d_reg    <= 1'b1;
         cnt_reg      <= '0;
         shift_reg    <= '0;
         ack_drv_reg  <= 1'b0;
         ack_seen_reg <= 1'b0;
         gain_reg     <= gain_setting_s'(GAIN_RESET);
         chan_reg     <= channel_control_s'(CHAN_RESET);
      end else begin
         state_reg    <= state_next;
         scl_d_reg    <= scl_d_next;
         sda_d_reg    <= sda_d_next;
         cnt_reg      <= cnt_next;
         shift_reg    <= shift_next;
         ack_drv_reg  <= ack_drv_next;
         ack_seen_reg <= ack_seen_next;
         gain_reg     <= gain_next;
         chan_reg     <= chan_next;
      end
   end

   // ------------------------------------------------------------
   // output stage
   // ------------------------------------------------------------
   // every output but o_sda (tied low) is a flop; the enable is registered from ack_drv_next, not ack_drv_reg
   logic [3:0] pre_o_reg;
   logic [2:0] post_o_reg;
   logic [5:0] chan_o_reg;
   logic       lpf_o_reg;
   logic       oe_n_reg;
   logic       lpf_next;

   always_comb begin
      lpf_next = (chan_reg.mode == MODE_CANCEL);
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         pre_o_reg  <= '0;
         post_o_reg <= '0;
         chan_o_reg <= '0;
         lpf_o_reg  <= 1'b1;
         oe_n_reg   <= 1'b1;
      end else begin
         pre_o_reg  <= gain_reg.pre_gain;
         post_o_reg <= post_sat(gain_reg.post_gain);
         chan_o_reg <= chan_reg[5:0];
         lpf_o_reg  <= lpf_next;
         oe_n_reg   <= ~ack_drv_next;
      end
   end

   assign o_sda                 = 1'b0;
   assign o_sda_oe_n            = oe_n_reg;
   assign o_pre_gain            = pre_o_reg;
   assign o_post_gain           = post_o_reg;
   assign o_mute_ch1            = chan_o_reg[0];
   assign o_mute_ch2            = chan_o_reg[1];
   assign o_en_ch1              = chan_o_reg[2];
   assign o_en_ch2              = chan_o_reg[3];
   assign o_mode                = chan_o_reg[5:4];
   assign o_output_lowpass_path = lpf_o_reg;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   property p_lpf_mode;
      @(posedge i_core_clk) disable iff (i_rst)
      ##1 o_output_lowpass_path == ($past(chan_reg.mode) == MODE_CANCEL);
   endproperty
   a_lpf_mode: assert property (p_lpf_mode) else $error("lowpass path wrong for mode");

   property p_post_sat;
      @(posedge i_core_clk) disable iff (i_rst)
      ##1 o_post_gain == (($past(gain_reg.post_gain) >= POST_SAT_CODE) ? POST_SAT_CODE
                          : $past(gain_reg.post_gain));
   endproperty
   a_post_sat: assert property (p_post_sat) else $error("post gain above saturation");

   property p_gain_hold;
      @(posedge i_core_clk) disable iff (i_rst)
      (state_reg != ST_DATA_ACK) |=> $stable(gain_reg) && $stable(chan_reg);
   endproperty
   a_gain_hold: assert property (p_gain_hold) else $error("register changed outside ack");

   // end of the acknowledge clock of a data byte, with no framing event
   sequence s_commit;
      state_reg == ST_DATA_ACK && scl_fall && ack_seen_reg && !start_cond && !stop_cond;
   endsequence

   property p_route_gain;
      @(posedge i_core_clk) disable iff (i_rst)
      (s_commit ##0 !shift_reg[SEL_BIT]) |=> gain_reg == $past(shift_reg[6:0])
                                            && $stable(chan_reg);
   endproperty
   a_route_gain: assert property (p_route_gain) else $error("gain write misrouted");

   property p_route_chan;
      @(posedge i_core_clk) disable iff (i_rst)
      (s_commit ##0 shift_reg[SEL_BIT]) |=> chan_reg == $past(shift_reg[6:0])
                                           && $stable(gain_reg);
   endproperty
   a_route_chan: assert property (p_route_chan) else $error("channel write misrouted");

   property p_no_read_ack;
      @(posedge i_core_clk) disable iff (i_rst)
      (state_reg == ST_IGNORE) |-> ##1 o_sda_oe_n;
   endproperty
   a_no_read_ack: assert property (p_no_read_ack) else $error("acked ignored transfer");

   property p_data_ack;
      @(posedge i_core_clk) disable iff (i_rst)
      // the line is let go on the cycle that ends the acknowledge clock
      (state_reg == ST_DATA_ACK && !(scl_fall && ack_seen_reg) && !start_cond && !stop_cond)
         |-> ##1 !o_sda_oe_n;
   endproperty
   a_data_ack: assert property (p_data_ack) else $error("data byte not acked");

   property p_pre_follow;
      @(posedge i_core_clk) disable iff (i_rst)
      ##1 o_pre_gain == $past(gain_reg.pre_gain) && o_en_ch1 == $past(chan_reg.en_ch1)
          && o_mode == $past(chan_reg.mode);
   endproperty
   a_pre_follow: assert property (p_pre_follow) else $error("outputs do not follow regs");
endmodule

// [design/mic_amp_pkg.sv]
// constants and types for the microphone amplifier control register bank
// Behaviour
// - register one bits 3:0 are the pre-amp gain code, 6 to 36 dB, default zero
// - register one bits 6:4 are post-amp gain, codes 4 and up saturate at 18 dB
// - register two bits 0 and 1 mute channel one and two, reset unmuted
// - register two bits 2 and 3 enable channel one and two, reset disabled
// - register two bits 5:4 pick mode: cancel, channel one, channel two, sum
// - output low-pass path enabled only in noise cancelling mode
// - data bit 7 routes the payload to register one or register two
// - only writes are accepted; a read address gets no acknowledge
// - every received data byte of an accepted write is acknowledged by the slave; data after a read or another address gets none
package mic_amp_pkg;
   // ------------------------------------------------------------
   // bus framing
   // ------------------------------------------------------------
   localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h67;
   localparam logic [3:0] BITS_PER_BYTE    = 4'h8;
   localparam int         SEL_BIT          = 7;
   localparam int         RW_BIT           = 0;
   localparam logic       RW_WRITE         = 1'b0;
   localparam logic       SEL_GAIN         = 1'b0;

   // ------------------------------------------------------------
   // register fields and reset values
   // ------------------------------------------------------------
   localparam logic [6:0] GAIN_RESET       = 7'h00;
   localparam logic [6:0] CHAN_RESET       = 7'h00;
   localparam logic [2:0] POST_SAT_CODE    = 3'h4;
   localparam logic [1:0] MODE_CANCEL      = 2'h0;
   localparam logic [1:0] MODE_CH1         = 2'h1;
   localparam logic [1:0] MODE_CH2         = 2'h2;
   localparam logic [1:0] MODE_SUM         = 2'h3;

   typedef struct packed {
      logic [2:0] post_gain;
      logic [3:0] pre_gain;
   } gain_setting_s;

   typedef struct packed {
      logic       unused;
      logic [1:0] mode;
      logic       en_ch2;
      logic       en_ch1;
      logic       mute_ch2;
      logic       mute_ch1;
   } channel_control_s;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } rx_byte_s;
endpackage

// [design/mic_amp_sync.sv]
// two-flop synchroniser for the serial bus pins
`timescale 1ns/1ps
module mic_amp_sync #(
   parameter logic RESET_VAL = 1'b1
) (
   input  wire logic i_core_clk,
   input  wire logic i_rst,
   input  wire logic i_async,
   output logic      o_sync
);
   logic meta_reg;
   logic sync_reg;

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         meta_reg <= RESET_VAL;
         sync_reg <= RESET_VAL;
      end else begin
         meta_reg <= i_async;
         sync_reg <= meta_reg;
      end
   end

   assign o_sync = sync_reg;
endmodule

// [verif/bus_master_model.sv]
// serial bus master model: drives the clock and an open-drain data line
`timescale 1ns/1ps
module bus_master_model #(
   parameter int HALF = 8
) (
   input  wire logic i_core_clk,
   input  wire logic i_sda_line,
   output logic      o_scl,
   output logic      o_sda
);
   initial begin
      o_scl = 1'b1;
      o_sda = 1'b1;
   end

   task automatic idle(input int n);
      repeat (n) @(posedge i_core_clk);
   endtask

   task automatic start();
      o_sda <= 1'b0;
      idle(HALF);
      o_scl <= 1'b0;
   endtask

   // data moves two cycles after the clock falls, never while it is high
   task automatic send(input logic [7:0] b, input int n, output logic ack);
      ack = 1'b1;
      for (int i = 7; i > 7 - n; i--) begin
         idle(2);
         o_sda <= b[i];
         idle(HALF);
         o_scl <= 1'b1;
         idle(HALF);
         o_scl <= 1'b0;
      end
      if (n == 8) begin
         idle(2);
         o_sda <= 1'b1;
         idle(HALF);
         o_scl <= 1'b1;
         idle(HALF / 2);
         ack = i_sda_line;
         idle(HALF / 2);
         o_scl <= 1'b0;
      end
   endtask

   task automatic stop();
      idle(2);
      o_sda <= 1'b0;
      idle(HALF);
      o_scl <= 1'b1;
      idle(HALF);
      o_sda <= 1'b1;
      idle(HALF);
   endtask
endmodule

// [verif/tb_top.sv]
// self-checking bench for the mic amplifier control register bank
`timescale 1ns/1ps
module tb_top;
   import mic_amp_pkg::*;
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic       scl, sda_m, sda_out, sda_oe_n, sda_line;
   logic       mute1, mute2, en1, en2, lp;
   logic [3:0] pre;
   logic [2:0] post;
   logic [1:0] mode;
   logic [7:0] g, c;
   logic [2:0] a;
   int         error_cnt, check_count, cycles;

   always #2.5 clk = ~clk;
   // pull-up: the line is high unless someone pulls it low
   assign sda_line = sda_m & (sda_oe_n | sda_out);

   bus_master_model mst (.i_core_clk(clk), .i_sda_line(sda_line), .o_scl(scl), .o_sda(sda_m));

   mic_amp_control_registers uut (
      .i_core_clk(clk), .i_rst(rst), .i_scl(scl), .i_sda(sda_line),
      .o_sda(sda_out), .o_sda_oe_n(sda_oe_n), .o_pre_gain(pre), .o_post_gain(post),
      .o_mute_ch1(mute1), .o_mute_ch2(mute2), .o_en_ch1(en1), .o_en_ch2(en2),
      .o_mode(mode), .o_output_lowpass_path(lp));

   task automatic close_out();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   // one transfer: address, a full byte, then n bits of a second byte
   task automatic wr(input logic [7:0] ad, input logic [7:0] d0, input logic [7:0] d1,
                     input int n);
      mst.start();
      mst.send(ad, 8, a[2]);
      mst.send(d0, 8, a[1]);
      mst.send(d1, n, a[0]);
      mst.stop();
   endtask

   task automatic outs();
      chk("pre_gain", {4'h0, g[3:0]}, {4'h0, pre});
      chk("post_gain", {5'h0, g[6] ? POST_SAT_CODE : g[6:4]}, {5'h0, post});
      chk("mute", {6'h0, c[1:0]}, {6'h0, mute2, mute1});
      chk("enable", {6'h0, c[3:2]}, {6'h0, en2, en1});
      chk("mode", {6'h0, c[5:4]}, {6'h0, mode});
      chk("lowpass", {7'h0, c[5:4] == MODE_CANCEL}, {7'h0, lp});
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         error_cnt++;
         close_out();
      end
   end

   initial begin
      g = 8'h00;
      c = 8'h00;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      outs();
      // every mode, mute/enable pattern and post code, two bytes back to back
      for (int k = 0; k < 16; k++) begin
         g = {1'b0, k[2:0], 4'(15 - k)};
         c = {2'b10, k[1:0], k[3:0]};
         wr({DEV_ADDR_DEFAULT, RW_WRITE}, g, c, 8);
         chk("ack", 8'h00, {5'h0, a});
         outs();
      end
      // read request: no answer, data that follows is ignored
      wr({DEV_ADDR_DEFAULT, 1'b1}, 8'h7F, 8'hBF, 8);
      chk("read_ack", 8'h07, {5'h0, a});
      outs();
      // another device address is ignored as well
      wr({DEV_ADDR_DEFAULT ^ 7'h01, RW_WRITE}, 8'h11, 8'h81, 8);
      chk("addr_ack", 8'h07, {5'h0, a});
      outs();
      // first byte commits, second is cut after four bits
      g = 8'h25;
      wr({DEV_ADDR_DEFAULT, RW_WRITE}, g, 8'hA5, 4);
      chk("abort_ack", 8'h01, {5'h0, a});
      outs();
      close_out();
   end
endmodule
